//--- ebc_pkg.sv
// Package of constants for the external bus cycle and arbitration block
package ebc_pkg;
  // =====================================
  // Register map
  localparam logic [3:0] BUS_CONTROL_REG_ADDR = 4'h0;
  localparam logic [3:0] OPERATING_MODE_REG_ADDR = 4'h1;
  localparam logic [3:0] STATUS_ADDR = 4'h2;
  // =====================================
  // Field positions
  localparam int WAIT_LSB = 0;
  localparam int WAIT_W = 4;
  localparam int REQUEST_HOLD_BIT = 4;
  localparam int DRAM_TYPE_BIT = 5;
  localparam int ACK_SYNC_SELECT_BIT = 0;
  // =====================================
  // Reset values
  localparam logic [7:0] BUS_CONTROL_RST = 8'h01;
  localparam logic [7:0] OPERATING_MODE_RST = 8'h00;
  localparam logic [7:0] UNMAPPED_DATA = 8'h00;
  // =====================================
  // Arbitration states
  typedef enum logic [1:0] {
    EBC_SLAVE = 2'b00,
    EBC_PENDING = 2'b01,
    EBC_MASTER = 2'b10,
    EBC_RELEASE = 2'b11
  } ebc_arb_e;
  // Bus cycle states
  typedef enum logic [1:0] {
    EBC_IDLE = 2'b00,
    EBC_WAIT = 2'b01,
    EBC_FINISH = 2'b10
  } ebc_cyc_e;
endpackage : ebc_pkg

//--- ebc_core.sv
// External bus cycle control and bus arbitration logic
//
// Implementation choices: the strobed register port and the address map.
`timescale 1ns/1ps
module ebc_core (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic ext_access_req,
  input wire logic ext_access_write,
  output logic ext_access_done,
  input wire logic transfer_ack_n,
  input wire logic bus_grant_in_n,
  input wire logic bus_busy_line_in,
  output logic bus_busy_line_out,
  output logic bus_busy_line_oe,
  output logic bus_request_out_n,
  output logic read_strobe_n,
  output logic read_strobe_oe,
  output logic store_strobe_n,
  output logic store_strobe_oe,
  output logic is_master
);
  import ebc_pkg::*;

  logic [7:0] bus_control_reg_ff;
  logic [7:0] operating_mode_reg_ff;
  logic ack_meta_ff;
  logic ack_sync_ff;
  logic ack_seen;
  ebc_arb_e arb_ff;
  ebc_arb_e nxt_arb;
  ebc_cyc_e cyc_ff;
  ebc_cyc_e nxt_cyc;
  logic [3:0] wait_cnt_ff;
  logic cyc_write_ff;
  logic master_now;
  logic cyc_active;
  logic ack_enable;

  function automatic logic [3:0] ebc_min_waits(input logic [7:0] bus_control_reg);
    ebc_min_waits = bus_control_reg[WAIT_LSB +: WAIT_W];
  endfunction : ebc_min_waits

  // =====================================
  // Register port
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      bus_control_reg_ff <= BUS_CONTROL_RST;
      operating_mode_reg_ff <= OPERATING_MODE_RST;
    end else if (clk_en && reg_wr) begin
      if (reg_addr == BUS_CONTROL_REG_ADDR) begin
        bus_control_reg_ff <= reg_wdata;
      end
      if (reg_addr == OPERATING_MODE_REG_ADDR) begin
        operating_mode_reg_ff <= reg_wdata;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      reg_rdata <= UNMAPPED_DATA;
    end else if (clk_en) begin
      if (reg_rd) begin
        case (reg_addr)
          BUS_CONTROL_REG_ADDR: reg_rdata <= bus_control_reg_ff;
          OPERATING_MODE_REG_ADDR: reg_rdata <= operating_mode_reg_ff;
          STATUS_ADDR: reg_rdata <= {4'h0, cyc_active, bus_busy_line_in, arb_ff};
          default: reg_rdata <= UNMAPPED_DATA;
        endcase
      end else begin
        reg_rdata <= UNMAPPED_DATA;
      end
    end
  end

  // =====================================
  // Acknowledge input path
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ack_meta_ff <= 1'b0;
      ack_sync_ff <= 1'b0;
    end else if (clk_en) begin
      ack_meta_ff <= ~transfer_ack_n;
      ack_sync_ff <= ack_meta_ff;
    end
  end

  always_comb begin
    if (operating_mode_reg_ff[ACK_SYNC_SELECT_BIT]) begin
      ack_seen = ~transfer_ack_n;
    end else begin
      ack_seen = ack_sync_ff;
    end
  end

  // Extension only with nonzero minimum and not DRAM type
  assign ack_enable = (ebc_min_waits(bus_control_reg_ff) != 4'h0)
                      && !bus_control_reg_ff[DRAM_TYPE_BIT];

  assign master_now = (arb_ff == EBC_MASTER);
  assign cyc_active = (cyc_ff != EBC_IDLE);

  // =====================================
  // Arbitration
  always_comb begin
    nxt_arb = arb_ff;
    case (arb_ff)
      EBC_SLAVE: begin
        if (!bus_grant_in_n) begin
          nxt_arb = EBC_PENDING;
        end
      end
      EBC_PENDING: begin
        if (bus_grant_in_n) begin
          nxt_arb = EBC_SLAVE;
        end else if (bus_busy_line_in) begin
          nxt_arb = EBC_MASTER;
        end
      end
      EBC_MASTER: begin
        if (bus_grant_in_n && !cyc_active) begin
          nxt_arb = EBC_RELEASE;
        end
      end
      EBC_RELEASE: nxt_arb = EBC_SLAVE;
      default: nxt_arb = EBC_SLAVE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      arb_ff <= EBC_SLAVE;
    end else if (clk_en) begin
      arb_ff <= nxt_arb;
    end
  end

  // Busy held while master even when idle, driven high then floated
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      bus_busy_line_out <= 1'b1;
      bus_busy_line_oe <= 1'b0;
    end else if (clk_en) begin
      case (nxt_arb)
        EBC_MASTER: begin
          bus_busy_line_out <= 1'b0;
          bus_busy_line_oe <= 1'b1;
        end
        EBC_RELEASE: begin
          bus_busy_line_out <= 1'b1;
          bus_busy_line_oe <= 1'b1;
        end
        default: begin
          bus_busy_line_out <= 1'b1;
          bus_busy_line_oe <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      is_master <= 1'b0;
    end else if (clk_en) begin
      is_master <= (nxt_arb == EBC_MASTER);
    end
  end

  // Request from external accesses or hold bit, independent of mastership
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      bus_request_out_n <= 1'b1;
    end else if (clk_en) begin
      bus_request_out_n <= ~((ext_access_req && !ext_access_done)
                             || bus_control_reg_ff[REQUEST_HOLD_BIT]);
    end
  end

  // =====================================
  // Bus cycle
  always_comb begin
    nxt_cyc = cyc_ff;
    case (cyc_ff)
      EBC_IDLE: begin
        if (master_now && ext_access_req && !bus_grant_in_n && !ext_access_done) begin
          nxt_cyc = EBC_WAIT;
        end
      end
      EBC_WAIT: begin
        if (wait_cnt_ff == 4'h0) begin
          if (!ack_enable) begin
            nxt_cyc = EBC_FINISH;
          end else if (ack_seen) begin
            nxt_cyc = EBC_FINISH;
          end
        end
      end
      EBC_FINISH: nxt_cyc = EBC_IDLE;
      default: nxt_cyc = EBC_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cyc_ff <= EBC_IDLE;
      wait_cnt_ff <= 4'h0;
      cyc_write_ff <= 1'b0;
    end else if (clk_en) begin
      cyc_ff <= nxt_cyc;
      if (cyc_ff == EBC_IDLE && nxt_cyc == EBC_WAIT) begin
        wait_cnt_ff <= ebc_min_waits(bus_control_reg_ff);
        cyc_write_ff <= ext_access_write;
      end else if (cyc_ff == EBC_WAIT && wait_cnt_ff != 4'h0) begin
        wait_cnt_ff <= wait_cnt_ff - 4'h1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ext_access_done <= 1'b0;
    end else if (clk_en) begin
      ext_access_done <= (cyc_ff == EBC_FINISH);
    end
  end

  // Strobes: both driven only while master, at most one of the two low at a time
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      read_strobe_n <= 1'b1;
      store_strobe_n <= 1'b1;
      read_strobe_oe <= 1'b0;
      store_strobe_oe <= 1'b0;
    end else if (clk_en) begin
      read_strobe_oe <= (nxt_arb == EBC_MASTER);
      store_strobe_oe <= (nxt_arb == EBC_MASTER);
      if (nxt_cyc == EBC_WAIT) begin
        read_strobe_n <= (cyc_ff == EBC_IDLE) ? ext_access_write : cyc_write_ff;
        store_strobe_n <= (cyc_ff == EBC_IDLE) ? ~ext_access_write : ~cyc_write_ff;
      end else begin
        read_strobe_n <= 1'b1;
        store_strobe_n <= 1'b1;
      end
    end
  end

  // =====================================
  // Checks
  a_strobe_exclusive: assert property (@(posedge ref_clk) disable iff (rst)
    !(!read_strobe_n && !store_strobe_n)) else $error("both strobes low");
  a_read_float_slave: assert property (@(posedge ref_clk) disable iff (rst)
    (!is_master) |-> !read_strobe_oe) else $error("read strobe driven as slave");
  a_store_float_slave: assert property (@(posedge ref_clk) disable iff (rst)
    (!is_master) |-> !store_strobe_oe) else $error("store strobe driven as slave");
  a_hold_forces_req: assert property (@(posedge ref_clk) disable iff (rst)
    (clk_en && bus_control_reg_ff[REQUEST_HOLD_BIT]) |=> !bus_request_out_n)
    else $error("hold bit did not force request");
  a_ack_ends_cycle: assert property (@(posedge ref_clk) disable iff (rst)
    (clk_en && cyc_ff == EBC_WAIT && wait_cnt_ff == 4'h0 && ack_seen)
    |=> cyc_ff == EBC_FINISH) else $error("ack did not end cycle");
  a_wait_stretch: assert property (@(posedge ref_clk) disable iff (rst)
    (clk_en && cyc_ff == EBC_WAIT && wait_cnt_ff == 4'h0 && ack_enable && !ack_seen)
    |=> cyc_ff == EBC_WAIT) else $error("cycle not stretched");
  a_min_waits: assert property (@(posedge ref_clk) disable iff (rst)
    (clk_en && cyc_ff == EBC_WAIT && wait_cnt_ff != 4'h0) |=> cyc_ff == EBC_WAIT)
    else $error("cycle ended before minimum waits");
  a_busy_wait: assert property (@(posedge ref_clk) disable iff (rst)
    (arb_ff == EBC_PENDING && !bus_busy_line_in) |=> arb_ff != EBC_MASTER)
    else $error("took bus while busy");
  a_release_idle: assert property (@(posedge ref_clk) disable iff (rst)
    (arb_ff == EBC_MASTER && cyc_active) |=> arb_ff == EBC_MASTER)
    else $error("mastership dropped mid cycle");
  a_reset_slave: assert property (@(posedge ref_clk)
    rst |=> (arb_ff == EBC_SLAVE && bus_request_out_n))
    else $error("reset did not restore slave");
endmodule : ebc_core

//--- ebc_far_model.sv
// Model of the external arbiter and memory responder
`timescale 1ns/1ps
module ebc_far_model (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic give_grant,
  input wire logic other_busy,
  input wire logic [3:0] ack_delay,
  input wire logic strobe_act,
  input wire logic busy_out,
  input wire logic busy_oe,
  output logic bus_grant_in_n,
  output logic transfer_ack_n,
  output logic busy_wire
);
  logic [3:0] cnt_ff;
  // =====================================
  // Grant moves only on the clock edge
  always_ff @(posedge ref_clk) begin
    if (rst) bus_grant_in_n <= 1'b1;
    else bus_grant_in_n <= ~give_grant;
  end
  // =====================================
  // Ack low after delay, high again once strobe ends
  always_ff @(posedge ref_clk) begin
    if (rst || !strobe_act) begin
      cnt_ff <= 4'h0;
      transfer_ack_n <= 1'b1;
    end else if (cnt_ff >= ack_delay) transfer_ack_n <= 1'b0;
    else cnt_ff <= cnt_ff + 4'h1;
  end
  // Pull-up holds the released busy line high
  assign busy_wire = busy_oe ? busy_out : ~other_busy;
endmodule : ebc_far_model

//--- test_ebc_core.sv
// Testbench for the external bus cycle and arbitration block
`timescale 1ns/1ps
module test_ebc_core;
  import ebc_pkg::*;
  logic ref_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [3:0] reg_addr = 4'h0, ack_delay = 4'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, base;
  logic ext_access_req = 1'b0, ext_access_write = 1'b0, ext_access_done;
  logic give_grant = 1'b0, other_busy = 1'b0, saw_high = 1'b0;
  logic clk_en = 1'b1;
  logic transfer_ack_n, bus_grant_in_n, busy_wire, busy_out, busy_oe, bus_request_out_n;
  logic read_strobe_n, read_strobe_oe, store_strobe_n, store_strobe_oe, is_master;
  int n_fail = 0, samples_checked = 0;
  always #12.5 ref_clk = ~ref_clk;
  ebc_core uut (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ext_access_req(ext_access_req), .ext_access_write(ext_access_write),
    .ext_access_done(ext_access_done), .transfer_ack_n(transfer_ack_n),
    .bus_grant_in_n(bus_grant_in_n), .bus_busy_line_in(busy_wire),
    .bus_busy_line_out(busy_out), .bus_busy_line_oe(busy_oe),
    .bus_request_out_n(bus_request_out_n), .read_strobe_n(read_strobe_n),
    .read_strobe_oe(read_strobe_oe), .store_strobe_n(store_strobe_n),
    .store_strobe_oe(store_strobe_oe), .is_master(is_master));
  ebc_far_model far (.ref_clk(ref_clk), .rst(rst), .give_grant(give_grant),
    .other_busy(other_busy), .ack_delay(ack_delay),
    .strobe_act((~read_strobe_n & read_strobe_oe) | (~store_strobe_n & store_strobe_oe)),
    .busy_out(busy_out), .busy_oe(busy_oe), .bus_grant_in_n(bus_grant_in_n),
    .transfer_ack_n(transfer_ack_n), .busy_wire(busy_wire));
  // =====================================
  // Shared tasks
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask : check
  task close_out();
    if (n_fail == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out
  task reg_write(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : reg_write
  task reg_read(input logic [3:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    d = reg_rdata;
  endtask : reg_read
  task cfg(input logic [7:0] bus_control_reg, input logic [7:0] mode);
    reg_write(BUS_CONTROL_REG_ADDR, bus_control_reg);
    reg_write(OPERATING_MODE_REG_ADDR, mode);
  endtask : cfg
  task run(input logic w, input logic [3:0] dly, output logic [7:0] len);
    logic rq;
    len = 8'h00;
    rq = 1'b1;
    @(posedge ref_clk);
    ack_delay <= dly;
    ext_access_write <= w;
    ext_access_req <= 1'b1;
    for (int k = 0; k < 80 && ext_access_done !== 1'b1; k++) begin
      @(negedge ref_clk);
      if ((w ? store_strobe_n : read_strobe_n) === 1'b0) len++;
      rq &= bus_request_out_n;
    end
    check({7'h0, ext_access_done}, 8'h01, "access done");
    check({7'h0, rq}, 8'h00, "request raised");
    @(posedge ref_clk);
    ext_access_req <= 1'b0;
  endtask : run
  // =====================================
  // Monitors
  always @(negedge ref_clk) begin
    check({7'h0, ~read_strobe_n & ~store_strobe_n}, 8'h00, "both strobes");
    check({6'h0, read_strobe_oe & ~is_master, store_strobe_oe & ~is_master}, 8'h00, "oe");
    if (busy_oe === 1'b1 && busy_out === 1'b1) saw_high = 1'b1;
  end
  // =====================================
  // Scenarios
  task t_reset();
    logic [7:0] d;
    @(negedge ref_clk);
    check({5'h0, bus_request_out_n, busy_oe, is_master}, 8'h04, "reset outputs");
    reg_write(4'hF, 8'hFF);
    reg_read(BUS_CONTROL_REG_ADDR, d);
    check(d, BUS_CONTROL_RST, "bus control");
    reg_read(OPERATING_MODE_REG_ADDR, d);
    check(d, OPERATING_MODE_RST, "mode");
    reg_read(4'hF, d);
    check(d, UNMAPPED_DATA, "unmapped");
    check({7'h0, bus_request_out_n}, 8'h01, "idle request");
  endtask : t_reset
  task t_arb();
    logic [7:0] d;
    reg_write(BUS_CONTROL_REG_ADDR, 8'h11);
    repeat (2) @(negedge ref_clk);
    check({7'h0, bus_request_out_n}, 8'h00, "hold request");
    @(posedge ref_clk);
    other_busy <= 1'b1;
    give_grant <= 1'b1;
    repeat (6) @(posedge ref_clk);
    @(negedge ref_clk);
    check({7'h0, is_master}, 8'h00, "took busy bus");
    @(posedge ref_clk);
    other_busy <= 1'b0;
    repeat (4) @(negedge ref_clk);
    check({6'h0, is_master, busy_wire}, 8'h02, "mastership");
    reg_write(BUS_CONTROL_REG_ADDR, 8'h01);
    repeat (3) @(negedge ref_clk);
    check({6'h0, bus_request_out_n, is_master}, 8'h03, "parked");
    reg_read(STATUS_ADDR, d);
    check(d, {6'h00, EBC_MASTER}, "parked status");
  endtask : t_arb
  task t_freeze();
    logic [7:0] d;
    @(posedge ref_clk);
    clk_en <= 1'b0;
    reg_write(BUS_CONTROL_REG_ADDR, 8'h11);
    repeat (2) @(negedge ref_clk);
    check({6'h0, bus_request_out_n, is_master}, 8'h03, "frozen state");
    @(posedge ref_clk);
    clk_en <= 1'b1;
    reg_read(BUS_CONTROL_REG_ADDR, d);
    check(d, BUS_CONTROL_RST, "frozen write");
  endtask : t_freeze
  task t_cycles();
    logic [7:0] a, b;
    cfg(8'h01, 8'h01);
    run(1'b0, 4'h0, base);
    check(base, 8'h02, "one wait length");
    run(1'b1, 4'h3, b);
    check(b - base, 8'h03, "ack stretch");
    cfg(8'h06, 8'h01);
    run(1'b0, 4'h0, a);
    check(a, 8'h07, "six wait length");
    run(1'b1, 4'h2, b);
    check(b, a, "min waits");
    cfg(8'h21, 8'h01);
    run(1'b0, 4'h0, a);
    run(1'b0, 4'h5, b);
    check(b, a, "dram ignores ack");
    cfg(8'h00, 8'h01);
    run(1'b0, 4'h0, a);
    run(1'b0, 4'h5, b);
    check(b, a, "zero waits ignore ack");
    cfg(8'h01, 8'h00);
    run(1'b0, 4'h0, b);
    check(b - base, 8'h02, "async ack");
  endtask : t_cycles
  task t_release();
    logic [7:0] a;
    cfg(8'h01, 8'h01);
    saw_high = 1'b0;
    fork
      run(1'b0, 4'h6, a);
      begin
        repeat (3) @(posedge ref_clk);
        give_grant <= 1'b0;
      end
    join
    check(a - base, 8'h06, "cycle finished");
    repeat (4) @(negedge ref_clk);
    check({4'h0, bus_request_out_n, is_master, busy_oe, busy_wire}, 8'h09, "released");
    check({7'h0, saw_high}, 8'h01, "busy driven high");
  endtask : t_release
  initial begin
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    t_reset();
    t_arb();
    t_freeze();
    t_cycles();
    t_release();
    close_out();
  end
  initial begin
    #150000;
    n_fail++;
    close_out();
  end
endmodule : test_ebc_core
